/* ssc_pkg.sv */
// constants shared by the serial status and control block
package ssc_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CTL_ONE_OFS = 8'h38;
   localparam logic [7:0] CTL_TWO_OFS = 8'h39;
   localparam logic [7:0] CTL_THREE_OFS = 8'h3a;
   localparam logic [7:0] STATUS_ONE_OFS = 8'h3b;
   localparam logic [7:0] DATA_BUF_OFS = 8'h3d;
   // ----------------------------------------------------------------
   // control_one_reg fields
   // ----------------------------------------------------------------
   localparam int C1_ENABLE = 6;
   localparam int C1_MODE9 = 4;
   localparam int C1_WAKE = 3;
   localparam int C1_PEN = 1;
   localparam int C1_PTY = 0;
   // ----------------------------------------------------------------
   // control_two_reg fields
   // ----------------------------------------------------------------
   localparam int C2_TXE_IE = 7;
   localparam int C2_TXD_IE = 6;
   localparam int C2_RXF_IE = 5;
   localparam int C2_QUIET_IE = 4;
   localparam int C2_TX_ON = 3;
   localparam int C2_RX_ON = 2;
   localparam int C2_STANDBY = 1;
   localparam int C2_BRK = 0;
   // ----------------------------------------------------------------
   // control_three_reg fields
   // ----------------------------------------------------------------
   localparam int C3_RX9 = 7;
   localparam int C3_TX9 = 6;
   localparam int C3_OVR_IE = 3;
   localparam int C3_NOISE_IE = 2;
   localparam int C3_FRM_IE = 1;
   localparam int C3_PAR_IE = 0;
   // ----------------------------------------------------------------
   // status_one_reg fields
   // ----------------------------------------------------------------
   localparam int S1_TXE = 7;
   localparam int S1_TXD = 6;
   localparam int S1_RXF = 5;
   localparam int S1_QUIET = 4;
   localparam int S1_OVR = 3;
   localparam int S1_NOISE = 2;
   localparam int S1_FRM = 1;
   localparam int S1_PAR = 0;
   // ----------------------------------------------------------------
   // character lengths in bit times
   // ----------------------------------------------------------------
   localparam logic [3:0] LEN_SHORT = 4'ha;
   localparam logic [3:0] LEN_LONG = 4'hb;
   // ----------------------------------------------------------------
   // transmitter states
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      TX_IDLE = 5'h01,
      TX_PRE = 5'h02,
      TX_DATA = 5'h04,
      TX_BREAK = 5'h08,
      TX_MARK = 5'h10
   } ssc_tx_state_type;
endpackage

/* ssc_status_control.sv */
// status, flag and interrupt request logic of an async serial port
`timescale 1ns/1ps
module ssc_status_control (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic bit_tick,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   input wire logic rx_done,
   input wire logic [8:0] rx_char,
   input wire logic rx_noise,
   input wire logic rx_frame_err,
   input wire logic rx_parity_err,
   input wire logic rx_break,
   output logic rx_active,
   output logic nine_bit_mode,
   output logic parity_en,
   output logic parity_odd,
   output logic tx_irq,
   output logic rx_irq,
   output logic err_irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] sync;
      logic line;
      logic ctl_en;
      logic mode9;
      logic wake;
      logic pen;
      logic pty;
      logic txe_ie;
      logic txd_ie;
      logic rxf_ie;
      logic quiet_ie;
      logic tx_on;
      logic rx_on;
      logic rx_standby;
      logic break_send;
      logic rx_ninth_bit;
      logic tx_ninth_bit;
      logic ovr_ie;
      logic noise_ie;
      logic frm_ie;
      logic par_ie;
      logic [7:0] flags;
      logic [7:0] armed;
      logic idle_armed;
      logic pre_pend;
      logic [7:0] rx_buf;
      logic [7:0] tx_hold;
      ssc_pkg::ssc_tx_state_type tx_st;
      logic [10:0] tx_sh;
      logic [3:0] tx_cnt;
      logic [3:0] idle_cnt;
      logic [7:0] rd_data;
      logic tx_out;
      logic tx_irq;
      logic rx_irq;
      logic err_irq;
      logic rx_act;
   } ssc_state_type;

   ssc_state_type s_r;
   ssc_state_type s_nxt;

   function automatic logic parity_of(input logic [7:0] d, input logic odd);
      parity_of = (^d) ^ odd;
   endfunction

   function automatic logic [3:0] frame_len(input logic m9);
      frame_len = m9 ? ssc_pkg::LEN_LONG : ssc_pkg::LEN_SHORT;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic wr_c1, wr_c2, wr_c3, wr_data, rd_stat, rd_data;
   logic rx_take, wake_char, idle_hit, frame_end, tx_load;
   logic [3:0] len;
   logic [7:0] d;

   always_comb begin
      s_nxt = s_r;
      wr_c1 = reg_wr && reg_addr == ssc_pkg::CTL_ONE_OFS;
      wr_c2 = reg_wr && reg_addr == ssc_pkg::CTL_TWO_OFS;
      wr_c3 = reg_wr && reg_addr == ssc_pkg::CTL_THREE_OFS;
      wr_data = reg_wr && reg_addr == ssc_pkg::DATA_BUF_OFS;
      rd_stat = reg_rd && reg_addr == ssc_pkg::STATUS_ONE_OFS;
      rd_data = reg_rd && reg_addr == ssc_pkg::DATA_BUF_OFS;
      len = frame_len(s_r.mode9);
      tx_load = 1'b0;
      d = 8'h00;

      // pin: a change counts once the last two stages agree
      s_nxt.sync = {s_r.sync[1:0], serial_in_pin};
      if (s_r.sync[2] == s_r.sync[1]) begin
         s_nxt.line = s_r.sync[2];
      end

      // register writes
      if (wr_c1) begin
         s_nxt.ctl_en = reg_wdata[ssc_pkg::C1_ENABLE];
         s_nxt.mode9 = reg_wdata[ssc_pkg::C1_MODE9];
         s_nxt.wake = reg_wdata[ssc_pkg::C1_WAKE];
         s_nxt.pen = reg_wdata[ssc_pkg::C1_PEN];
         s_nxt.pty = reg_wdata[ssc_pkg::C1_PTY];
      end
      if (wr_c2) begin
         s_nxt.txe_ie = reg_wdata[ssc_pkg::C2_TXE_IE];
         s_nxt.txd_ie = reg_wdata[ssc_pkg::C2_TXD_IE];
         s_nxt.rxf_ie = reg_wdata[ssc_pkg::C2_RXF_IE];
         s_nxt.quiet_ie = reg_wdata[ssc_pkg::C2_QUIET_IE];
         s_nxt.rx_standby = reg_wdata[ssc_pkg::C2_STANDBY];
         s_nxt.break_send = reg_wdata[ssc_pkg::C2_BRK];
         // transmit and receive enables are locked while the port is off
         if (s_r.ctl_en) begin
            s_nxt.tx_on = reg_wdata[ssc_pkg::C2_TX_ON];
            s_nxt.rx_on = reg_wdata[ssc_pkg::C2_RX_ON];
            if (reg_wdata[ssc_pkg::C2_TX_ON] && !s_r.tx_on) begin
               s_nxt.pre_pend = 1'b1;
            end
            if (reg_wdata[ssc_pkg::C2_RX_ON] && !s_r.rx_on) begin
               s_nxt.idle_armed = 1'b0;
            end
         end
      end
      if (wr_c3) begin
         s_nxt.tx_ninth_bit = reg_wdata[ssc_pkg::C3_TX9];
         s_nxt.ovr_ie = reg_wdata[ssc_pkg::C3_OVR_IE];
         s_nxt.noise_ie = reg_wdata[ssc_pkg::C3_NOISE_IE];
         s_nxt.frm_ie = reg_wdata[ssc_pkg::C3_FRM_IE];
         s_nxt.par_ie = reg_wdata[ssc_pkg::C3_PAR_IE];
      end

      // ----------------------------------------------------------------
      // clearing sequences; clears come first so later sets win
      // ----------------------------------------------------------------
      if (rd_stat) begin
         // only flags already set at this read may clear later
         s_nxt.armed = s_r.flags & ~(8'h01 << ssc_pkg::S1_TXD);
      end
      if (wr_data) begin
         s_nxt.tx_hold = reg_wdata;
         if (s_r.armed[ssc_pkg::S1_TXE]) begin
            s_nxt.flags[ssc_pkg::S1_TXE] = 1'b0;
            s_nxt.armed[ssc_pkg::S1_TXE] = 1'b0;
         end
      end
      if (rd_data) begin
         s_nxt.flags[5:0] = s_r.flags[5:0] & ~s_r.armed[5:0];
         s_nxt.armed[5:0] = 6'h00;
         if (s_r.armed[ssc_pkg::S1_QUIET]) begin
            s_nxt.idle_armed = 1'b0;
         end
      end

      // ----------------------------------------------------------------
      // receive events
      // ----------------------------------------------------------------
      wake_char = s_r.mode9 ? rx_char[8] : rx_char[7];
      rx_take = rx_done && s_r.rx_on && s_r.ctl_en &&
         (!s_r.rx_standby || (s_r.wake && wake_char));
      if (rx_done && s_r.rx_standby && s_r.wake && wake_char) begin
         s_nxt.rx_standby = 1'b0;
      end
      if (rx_take) begin
         if (s_nxt.flags[ssc_pkg::S1_RXF]) begin
            s_nxt.flags[ssc_pkg::S1_OVR] = 1'b1;
         end else begin
            s_nxt.rx_buf = rx_char[7:0];
            // in nine-bit mode a break leaves a zero ninth bit
            s_nxt.rx_ninth_bit = s_r.mode9 ? rx_char[8] && !rx_break :
               rx_char[7];
            s_nxt.flags[ssc_pkg::S1_RXF] = 1'b1;
            s_nxt.idle_armed = 1'b1;
            if (rx_noise) begin
               s_nxt.flags[ssc_pkg::S1_NOISE] = 1'b1;
            end
            if (rx_frame_err || rx_break) begin
               s_nxt.flags[ssc_pkg::S1_FRM] = 1'b1;
            end
            if (rx_parity_err) begin
               s_nxt.flags[ssc_pkg::S1_PAR] = 1'b1;
            end
         end
      end

      // idle line: count ones at the bit rate
      idle_hit = 1'b0;
      if (!(s_r.rx_on && s_r.ctl_en)) begin
         s_nxt.idle_cnt = 4'h0;
      end else if (bit_tick) begin
         if (!s_r.line) begin
            s_nxt.idle_cnt = 4'h0;
         end else if (s_r.idle_cnt != len) begin
            s_nxt.idle_cnt = s_r.idle_cnt + 4'h1;
            idle_hit = s_r.idle_cnt == len - 4'h1;
         end
      end
      if (idle_hit && s_nxt.idle_armed) begin
         s_nxt.flags[ssc_pkg::S1_QUIET] = 1'b1;
      end
      if (idle_hit && s_r.rx_standby && !s_r.wake) begin
         s_nxt.rx_standby = 1'b0;
      end

      // ----------------------------------------------------------------
      // transmitter sequencing
      // ----------------------------------------------------------------
      frame_end = 1'b0;
      if (bit_tick) begin
         if (s_r.tx_st == ssc_pkg::TX_IDLE || s_r.tx_cnt == 4'h0) begin
            frame_end = 1'b1;
         end else begin
            s_nxt.tx_cnt = s_r.tx_cnt - 4'h1;
            s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]};
         end
      end
      if (frame_end) begin
         s_nxt.tx_cnt = len - 4'h1;
         if (s_r.tx_st == ssc_pkg::TX_BREAK && !s_r.break_send) begin
            s_nxt.tx_st = ssc_pkg::TX_MARK;
            s_nxt.tx_cnt = 4'h0;
         end else if (!s_r.tx_on || !s_r.ctl_en) begin
            s_nxt.tx_st = ssc_pkg::TX_IDLE;
         end else if (s_r.pre_pend) begin
            s_nxt.tx_st = ssc_pkg::TX_PRE;
            s_nxt.pre_pend = 1'b0;
         end else if (s_r.break_send) begin
            s_nxt.tx_st = ssc_pkg::TX_BREAK;
         end else if (!s_r.flags[ssc_pkg::S1_TXE]) begin
            s_nxt.tx_st = ssc_pkg::TX_DATA;
            tx_load = 1'b1;
         end else begin
            s_nxt.tx_st = ssc_pkg::TX_IDLE;
         end
      end
      if (tx_load) begin
         d = s_r.tx_hold;
         if (s_r.pen && !s_r.mode9) begin
            d[7] = parity_of({1'b0, d[6:0]}, s_r.pty);
         end
         if (s_r.mode9) begin
            s_nxt.tx_sh = {1'b1, s_r.pen ? parity_of(d, s_r.pty) :
               s_r.tx_ninth_bit, d, 1'b0};
         end else begin
            s_nxt.tx_sh = {2'b11, d, 1'b0};
         end
         s_nxt.flags[ssc_pkg::S1_TXE] = 1'b1;
      end
      if (!s_r.ctl_en) begin
         s_nxt.flags[ssc_pkg::S1_TXE] = 1'b1;
      end

      // done flag follows the queue, so it drops as soon as work waits
      s_nxt.flags[ssc_pkg::S1_TXD] = !s_nxt.ctl_en ||
         (s_nxt.flags[ssc_pkg::S1_TXE] &&
         s_nxt.tx_st == ssc_pkg::TX_IDLE && !s_nxt.pre_pend &&
         !(s_nxt.break_send && s_nxt.tx_on));

      unique case (s_nxt.tx_st)
         ssc_pkg::TX_BREAK: s_nxt.tx_out = 1'b0;
         ssc_pkg::TX_DATA: s_nxt.tx_out = s_nxt.tx_sh[0];
         ssc_pkg::TX_IDLE, ssc_pkg::TX_PRE,
         ssc_pkg::TX_MARK: s_nxt.tx_out = 1'b1;
         default: s_nxt.tx_out = 1'b1;
      endcase

      // ----------------------------------------------------------------
      // interrupt requests
      // ----------------------------------------------------------------
      s_nxt.tx_irq = s_nxt.ctl_en &&
         ((s_nxt.flags[ssc_pkg::S1_TXE] && s_nxt.txe_ie) ||
         (s_nxt.flags[ssc_pkg::S1_TXD] && s_nxt.txd_ie));
      s_nxt.rx_irq = !s_nxt.rx_standby &&
         ((s_nxt.flags[ssc_pkg::S1_RXF] && s_nxt.rxf_ie) ||
         (s_nxt.flags[ssc_pkg::S1_QUIET] && s_nxt.quiet_ie));
      s_nxt.rx_act = s_nxt.rx_on && s_nxt.ctl_en;
      s_nxt.err_irq =
         (s_nxt.flags[ssc_pkg::S1_OVR] && s_nxt.ovr_ie) ||
         (s_nxt.flags[ssc_pkg::S1_NOISE] && s_nxt.noise_ie) ||
         (s_nxt.flags[ssc_pkg::S1_FRM] && s_nxt.frm_ie) ||
         (s_nxt.flags[ssc_pkg::S1_PAR] && s_nxt.par_ie);

      // ----------------------------------------------------------------
      // read port, data one cycle after the strobe
      // ----------------------------------------------------------------
      s_nxt.rd_data = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            ssc_pkg::CTL_ONE_OFS: begin
               s_nxt.rd_data[ssc_pkg::C1_ENABLE] = s_r.ctl_en;
               s_nxt.rd_data[ssc_pkg::C1_MODE9] = s_r.mode9;
               s_nxt.rd_data[ssc_pkg::C1_WAKE] = s_r.wake;
               s_nxt.rd_data[ssc_pkg::C1_PEN] = s_r.pen;
               s_nxt.rd_data[ssc_pkg::C1_PTY] = s_r.pty;
            end
            ssc_pkg::CTL_TWO_OFS: begin
               s_nxt.rd_data = {s_r.txe_ie, s_r.txd_ie, s_r.rxf_ie,
                  s_r.quiet_ie, s_r.tx_on, s_r.rx_on, s_r.rx_standby,
                  s_r.break_send};
            end
            ssc_pkg::CTL_THREE_OFS: begin
               s_nxt.rd_data = {s_r.rx_ninth_bit, s_r.tx_ninth_bit, 2'b00,
                  s_r.ovr_ie, s_r.noise_ie, s_r.frm_ie, s_r.par_ie};
            end
            ssc_pkg::STATUS_ONE_OFS: s_nxt.rd_data = s_r.flags;
            ssc_pkg::DATA_BUF_OFS: s_nxt.rd_data = s_r.rx_buf;
            default: s_nxt.rd_data = 8'h00;
         endcase
      end

      // ----------------------------------------------------------------
      // synchronous reset; data buffers and ninth bits keep their value
      // ----------------------------------------------------------------
      if (reset) begin
         s_nxt = '0;
         s_nxt.rx_ninth_bit = s_r.rx_ninth_bit;
         s_nxt.tx_ninth_bit = s_r.tx_ninth_bit;
         s_nxt.rx_buf = s_r.rx_buf;
         s_nxt.tx_hold = s_r.tx_hold;
         s_nxt.sync = 3'h7;
         s_nxt.line = 1'b1;
         s_nxt.tx_st = ssc_pkg::TX_IDLE;
         s_nxt.tx_sh = 11'h7ff;
         s_nxt.tx_out = 1'b1;
         s_nxt.flags[ssc_pkg::S1_TXE] = 1'b1;
         s_nxt.flags[ssc_pkg::S1_TXD] = 1'b1;
         s_nxt.ovr_ie = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end

   assign reg_rdata = s_r.rd_data;
   assign serial_out_pin = s_r.tx_out;
   assign rx_active = s_r.rx_act;
   assign nine_bit_mode = s_r.mode9;
   assign parity_en = s_r.pen;
   assign parity_odd = s_r.pty;
   assign tx_irq = s_r.tx_irq;
   assign rx_irq = s_r.rx_irq;
   assign err_irq = s_r.err_irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_standby_mutes_rx: assert property (@(posedge clk) disable iff (reset)
      s_r.rx_standby |-> !rx_irq)
      else $error("receiver request raised in standby");

   a_mark_wakes_rx: assert property (@(posedge clk) disable iff (reset)
      rx_done && s_r.rx_standby && s_r.wake && wake_char
      |=> !s_r.rx_standby)
      else $error("address mark did not end standby");

   a_break_then_mark: assert property (@(posedge clk) disable iff (reset)
      s_r.tx_st == ssc_pkg::TX_BREAK && frame_end && !s_r.break_send
      |=> s_r.tx_st == ssc_pkg::TX_MARK && serial_out_pin)
      else $error("no mark after the last break");

   a_break_no_gap: assert property (@(posedge clk) disable iff (reset)
      s_r.tx_st == ssc_pkg::TX_BREAK && frame_end && s_r.break_send &&
      s_r.tx_on && s_r.ctl_en
      |=> s_r.tx_st == ssc_pkg::TX_BREAK && !serial_out_pin)
      else $error("gap between held breaks");

   a_empty_on_load: assert property (@(posedge clk) disable iff (reset)
      tx_load |=> s_r.flags[ssc_pkg::S1_TXE] &&
      s_r.tx_sh[8:1] == $past(d))
      else $error("load did not set buffer empty");

   a_err_gate: assert property (@(posedge clk) disable iff (reset)
      ##1 err_irq == |($past(s_nxt.flags[3:0]) &
      $past({s_nxt.ovr_ie, s_nxt.noise_ie, s_nxt.frm_ie, s_nxt.par_ie})))
      else $error("error request not gated by its enable");

   a_done_idle_only: assert property (@(posedge clk) disable iff (reset)
      s_r.tx_st != ssc_pkg::TX_IDLE && s_r.ctl_en
      |-> !s_r.flags[ssc_pkg::S1_TXD])
      else $error("done flag set while sending");

   a_overrun_keeps: assert property (@(posedge clk) disable iff (reset)
      rx_take && s_r.flags[ssc_pkg::S1_RXF] && !rd_data
      |=> s_r.flags[ssc_pkg::S1_OVR] && s_r.rx_buf == $past(s_r.rx_buf))
      else $error("overrun lost buffered data");

   a_overrun_late: assert property (@(posedge clk) disable iff (reset)
      rd_data && !s_r.armed[ssc_pkg::S1_OVR] && s_r.flags[ssc_pkg::S1_OVR]
      |=> s_r.flags[ssc_pkg::S1_OVR])
      else $error("overrun cleared without being seen");

   a_idle_needs_char: assert property (@(posedge clk) disable iff (reset)
      $rose(s_r.flags[ssc_pkg::S1_QUIET]) |-> $past(s_nxt.idle_armed))
      else $error("idle flag set before a character");

   a_preamble_first: assert property (@(posedge clk) disable iff (reset)
      s_r.pre_pend && frame_end && s_r.tx_on && s_r.ctl_en &&
      s_r.tx_st != ssc_pkg::TX_BREAK
      |=> s_r.tx_st == ssc_pkg::TX_PRE ##1 serial_out_pin)
      else $error("preamble not sent first");
endmodule

/* ssc_far_end.sv */
// far-end partner: bit pacing, line level and received characters
`timescale 1ns/1ps
module ssc_far_end (
   input wire logic clk,
   input wire logic quiet,
   output logic bit_tick,
   output logic serial_in_pin,
   output logic rx_done,
   output logic [8:0] rx_char,
   output logic [3:0] rx_flags
);
   logic [1:0] cnt_r;
   initial begin
      cnt_r = 2'h0;
      bit_tick = 1'b0;
      rx_done = 1'b0;
      rx_char = 9'h000;
      rx_flags = 4'h0;
   end
   // one bit time every four clocks keeps frames short
   always @(posedge clk) begin
      cnt_r <= cnt_r + 2'h1;
      bit_tick <= (cnt_r == 2'h3);
   end
   // low while traffic runs, so no idle run builds up
   assign serial_in_pin = quiet;
   task automatic send(input logic [8:0] c, input logic [3:0] f);
      @(posedge clk);
      rx_char <= c;
      rx_flags <= f;
      rx_done <= 1'b1;
      @(posedge clk);
      rx_done <= 1'b0;
      // qualifiers are stale once the pulse is gone
      rx_char <= ~c;
      rx_flags <= ~f;
   endtask
endmodule

/* ssc_status_control_tb.sv */
// self-checking testbench of the serial status and control block
`timescale 1ns/1ps
module ssc_status_control_tb;
   logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, quiet = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic bit_tick, serial_in_pin, serial_out_pin, rx_done, rd_d = 1'b0;
   logic [8:0] rx_char;
   logic [3:0] rx_flags;
   logic tx_irq, rx_irq, err_irq;
   logic [7:0] exp_q[$];
   logic [31:0] lfsr = 32'hf9e6b4df;
   logic [7:0] d0, c1, c2;
   int fail_count = 0, cmp_count = 0;
   initial forever #10 clk = ~clk;
   ssc_status_control i_ssc_status_control (.clk(clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_tick(bit_tick),
      .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
      .rx_done(rx_done), .rx_char(rx_char), .rx_noise(rx_flags[3]),
      .rx_frame_err(rx_flags[2]), .rx_parity_err(rx_flags[1]),
      .rx_break(rx_flags[0]), .rx_active(), .nine_bit_mode(),
      .parity_en(), .parity_odd(), .tx_irq(tx_irq), .rx_irq(rx_irq),
      .err_irq(err_irq));
   ssc_far_end i_ssc_far_end (.clk(clk), .quiet(quiet), .bit_tick(bit_tick),
      .serial_in_pin(serial_in_pin), .rx_done(rx_done), .rx_char(rx_char),
      .rx_flags(rx_flags));
   // ----------------------------------------------------------------
   // bus tasks, checks and closing
   // ----------------------------------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   task automatic cmp_data(input logic [7:0] got, input logic [7:0] e);
      cmp_count++;
      if (got !== e) begin
         fail_count++;
         $display("CHECK FAILED %0t read %h expected %h", $time, got, e);
      end
   endtask
   // output picked after the wait: 0 tx, 1 rx, 2 error request, 3 line
   task automatic cmp_irq(input int sel, input logic e);
      logic got;
      repeat (3) @(posedge clk);
      @(negedge clk);
      got = sel == 0 ? tx_irq : sel == 1 ? rx_irq :
         sel == 2 ? err_irq : serial_out_pin;
      cmp_count++;
      if (got !== e) begin
         fail_count++;
         $display("CHECK FAILED %0t output %0d is %b expected %b", $time,
            sel, got, e);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge clk) rd_d <= reg_rd;
   always @(negedge clk) begin
      if (rd_d) begin
         if (exp_q.size() == 0)
            cmp_data(reg_rdata, 8'hxx);
         else
            cmp_data(reg_rdata, exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      final_report();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      lfsr = nxt(lfsr);
      d0 = lfsr[7:0];
      lfsr = nxt(lfsr);
      c1 = lfsr[7:0];
      lfsr = nxt(lfsr);
      c2 = lfsr[15:8];
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      rd(8'h3b, 8'hc0);
      rd(8'h3e, 8'h00);
      wr(8'h38, 8'h40);
      wr(8'h39, 8'h0c);
      wr(8'h3a, 8'h4f);
      rd(8'h3b, 8'h80);
      wr(8'h3d, d0);
      rd(8'h3b, 8'h00);
      repeat (60) @(posedge clk);
      rd(8'h3b, 8'h80);
      repeat (60) @(posedge clk);
      rd(8'h3b, 8'hc0);
      i_ssc_far_end.send({1'b0, c1}, 4'h0);
      rd(8'h3b, 8'he0);
      i_ssc_far_end.send({1'b0, c2}, 4'h0);
      rd(8'h3d, c1);
      rd(8'h3b, 8'hc8);
      rd(8'h3d, c1);
      rd(8'h3b, 8'hc0);
      rd(8'h3a, {c1[7], 7'h4f});
      i_ssc_far_end.send({1'b0, c2}, 4'he);
      cmp_irq(2, 1'b1);
      rd(8'h3b, 8'he7);
      wr(8'h3a, 8'h40);
      cmp_irq(2, 1'b0);
      rd(8'h3d, c2);
      rd(8'h3b, 8'hc0);
      wr(8'h38, 8'h48);
      wr(8'h39, 8'h1e);
      quiet <= 1'b1;
      repeat (60) @(posedge clk);
      rd(8'h3b, 8'hd0);
      cmp_irq(1, 1'b0);
      i_ssc_far_end.send({1'b0, c1 | 8'h80}, 4'h0);
      cmp_irq(1, 1'b1);
      rd(8'h39, 8'h1c);
      wr(8'h39, 8'hcc);
      cmp_irq(0, 1'b1);
      // break held across two frames, long after empty was set
      wr(8'h39, 8'h0d);
      rd(8'h3b, 8'hb0);
      repeat (50) @(posedge clk);
      cmp_irq(3, 1'b0);
      wr(8'h39, 8'h0c);
      repeat (60) @(posedge clk);
      cmp_irq(3, 1'b1);
      rd(8'h3b, 8'hf0);
      repeat (4) @(posedge clk);
      final_report();
   end
endmodule
